// ===== logic/rpsc_pkg.sv
package rpsc_pkg;

  // Settings register byte addresses
  localparam logic [7:0] WAKE_SET_ADDR = 8'h2b;
  localparam logic [7:0] PRE_SET_ADDR  = 8'h2c;
  localparam logic [7:0] DATA_SET_ADDR = 8'h2d;

  // Values after reset
  localparam logic [7:0] WAKE_SET_RST  = 8'h00;
  localparam logic [7:0] PRE_SET_RST   = 8'h00;
  localparam logic [7:0] DATA_SET_RST  = 8'h00;
  localparam logic [7:0] RDATA_RST     = 8'h00;

  // Field positions, common to all three settings registers
  localparam int GAP_MSB  = 7;
  localparam int GAP_LSB  = 6;
  localparam int TYPE_MSB = 5;
  localparam int TYPE_LSB = 4;
  localparam int INIT_MSB = 3;
  localparam int INIT_LSB = 2;
  localparam int ACQ_MSB  = 1;
  localparam int ACQ_LSB  = 0;

  // One demodulator sample per chip, two chips per bit
  localparam int CHIPS_PER_BIT   = 2;
  localparam int FRAC_W          = 4;
  localparam int LPF_SHORT_BITS  = 2;
  localparam int LPF_LONG_BITS   = 8;
  localparam int LPF_SHORT_SHIFT = $clog2(LPF_SHORT_BITS * CHIPS_PER_BIT);
  localparam int LPF_LONG_SHIFT  = $clog2(LPF_LONG_BITS * CHIPS_PER_BIT);

  // Acquisition lengths in bits
  localparam int ACQ_BITS_SHORT = 2;
  localparam int ACQ_BITS_MID   = 4;
  localparam int ACQ_BITS_LONG  = 8;
  localparam int ACQ_CNT_W      = 5;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAKE = 2'b01,
    PH_PRE  = 2'b10,
    PH_DATA = 2'b11
  } rpsc_phase_t;

  typedef enum logic [1:0] {
    SL_EDGE     = 2'b00,
    SL_HOLD     = 2'b01,
    SL_LP_SHORT = 2'b10,
    SL_LP_LONG  = 2'b11
  } rpsc_slicer_t;

  typedef enum logic [1:0] {
    INIT_NONE    = 2'b00,
    INIT_REG     = 2'b01,
    INIT_ACQ     = 2'b10,
    INIT_ACQ_RST = 2'b11
  } rpsc_init_t;

  typedef enum logic [1:0] {
    ACQ_OFF  = 2'b00,
    ACQ_2    = 2'b01,
    ACQ_4    = 2'b10,
    ACQ_8    = 2'b11
  } rpsc_acq_len_t;

endpackage

// ===== logic/rpsc_acq.sv
`timescale 1ns/1ps
module rpsc_acq #(
  parameter int DATA_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              start_i,
  input  wire logic              stop_i,
  input  wire logic [1:0]        len_i,
  input  wire logic [DATA_W-1:0] sample_i,
  input  wire logic              sample_valid_i,
  output logic [DATA_W-1:0]      result_o,
  output logic                   result_valid_o
);
  localparam int CW = rpsc_pkg::ACQ_CNT_W;
  localparam int AW = DATA_W + CW - 1;

  typedef struct packed {
    logic              run;
    logic [CW-1:0]     cnt;
    logic [AW-1:0]     acc;
    logic [DATA_W-1:0] result;
    logic              done;
  } rpsc_acq_state_t;

  rpsc_acq_state_t s_r;
  rpsc_acq_state_t s_nxt;
  logic [AW-1:0]   sum;

  function automatic logic [CW-1:0] win_last(input logic [1:0] len);
    case (rpsc_pkg::rpsc_acq_len_t'(len))
      rpsc_pkg::ACQ_2: win_last = CW'(rpsc_pkg::ACQ_BITS_SHORT * rpsc_pkg::CHIPS_PER_BIT - 1);
      rpsc_pkg::ACQ_4: win_last = CW'(rpsc_pkg::ACQ_BITS_MID * rpsc_pkg::CHIPS_PER_BIT - 1);
      rpsc_pkg::ACQ_8: win_last = CW'(rpsc_pkg::ACQ_BITS_LONG * rpsc_pkg::CHIPS_PER_BIT - 1);
      default:         win_last = '0;
    endcase
  endfunction

  function automatic int win_shift(input logic [1:0] len);
    case (rpsc_pkg::rpsc_acq_len_t'(len))
      rpsc_pkg::ACQ_2: win_shift = $clog2(rpsc_pkg::ACQ_BITS_SHORT * rpsc_pkg::CHIPS_PER_BIT);
      rpsc_pkg::ACQ_4: win_shift = $clog2(rpsc_pkg::ACQ_BITS_MID * rpsc_pkg::CHIPS_PER_BIT);
      rpsc_pkg::ACQ_8: win_shift = $clog2(rpsc_pkg::ACQ_BITS_LONG * rpsc_pkg::CHIPS_PER_BIT);
      default:         win_shift = 0;
    endcase
  endfunction

  always_comb
  begin
    sum = s_r.acc + AW'(sample_i);
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (stop_i || len_i == 2'b00)
    begin
      s_nxt.run = 1'b0;
      s_nxt.cnt = '0;
      s_nxt.acc = '0;
    end
    else if (start_i)
    begin
      s_nxt.run = 1'b1;
      s_nxt.cnt = '0;
      s_nxt.acc = '0;
    end
    else if (s_r.run && sample_valid_i)
    begin
      // Greater-or-equal guards a length change in mid window
      if (s_r.cnt >= win_last(len_i))
      begin
        s_nxt.result = DATA_W'(sum >> win_shift(len_i));
        s_nxt.done   = 1'b1;
        s_nxt.cnt    = '0;
        s_nxt.acc    = '0;
      end
      else
      begin
        s_nxt.acc = sum;
        s_nxt.cnt = s_r.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else if (ce_i)
      s_r <= s_nxt;
  end

  assign result_o       = s_r.result;
  assign result_valid_o = s_r.done;

  a_acq_zero_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && len_i == 2'b00) |=> !result_valid_o && !s_r.run)
    else $error("acquisition ran with zero length");

  a_acq_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && start_i && !stop_i && len_i != 2'b00) |=> (s_r.run && s_r.cnt == '0 && !s_r.done))
    else $error("acquisition start did not clear the window");
endmodule

// ===== logic/rpsc_edge.sv
`timescale 1ns/1ps
module rpsc_edge #(
  parameter int DATA_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              clear_i,
  input  wire logic [DATA_W-1:0] sample_i,
  input  wire logic              valid_i,
  input  wire logic [DATA_W-1:0] peak_i,
  output logic                   decision_o
);
  typedef struct packed {
    logic              lvl;
    logic [DATA_W-1:0] low;
    logic [DATA_W-1:0] high;
  } rpsc_edge_state_t;

  localparam rpsc_edge_state_t S_RST = '{lvl: 1'b0, low: '1, high: '0};

  rpsc_edge_state_t s_r;
  rpsc_edge_state_t s_nxt;

  // A swing of one full peak from the last extreme counts as an edge
  always_comb
  begin
    s_nxt = s_r;
    if (clear_i)
      s_nxt = S_RST;
    else if (valid_i)
    begin
      if (!s_r.lvl)
      begin
        if ({1'b0, sample_i} >= {1'b0, s_r.low} + {1'b0, peak_i})
        begin
          s_nxt.lvl  = 1'b1;
          s_nxt.high = sample_i;
        end
        else if (sample_i < s_r.low)
          s_nxt.low = sample_i;
      end
      else
      begin
        if ({1'b0, sample_i} + {1'b0, peak_i} <= {1'b0, s_r.high})
        begin
          s_nxt.lvl = 1'b0;
          s_nxt.low = sample_i;
        end
        else if (sample_i > s_r.high)
          s_nxt.high = sample_i;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      s_r <= S_RST;
    else if (ce_i)
      s_r <= s_nxt;
  end

  // Look-ahead so the caller registers the decision only once
  assign decision_o = s_nxt.lvl;
endmodule

// ===== logic/rpsc_slicer_cfg.sv
`timescale 1ns/1ps
// How it works
// - Wakeup phase uses wakeup settings register
// - Preamble phase uses preamble gaps and type
// - Data phase uses data gaps and type
// - Wakeup gap field is longest interval minus one
// - Preamble gap count applied in preamble phase
// - Data gap count applied in data phase
// - Type 00 edge, 01 level with held threshold
// - Type 10 level, four-chip low-pass threshold
// - Type 11 level, sixteen-chip low-pass threshold
// - Init code 00 never loads the threshold
// - Init code 01 loads initial value at start
// - Init code 10 acquires, updates on each result
// - Init code 11 also restarts on chip timeout
// - Acquisition length 0, 2, 4, 8 bits
// - Wakeup acquisition writes init value and threshold
// - Preamble init mode governs preamble and data
// - Preamble and data use preamble acquisition length
// - Edge slicer uses expected peak as reference
module rpsc_slicer_cfg #(
  parameter int DATA_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic [7:0]             reg_rdata_o,
  input  wire logic [1:0]        phase_i,
  input  wire logic              rx_start_i,
  input  wire logic              chip_timeout_i,
  input  wire logic [DATA_W-1:0] sample_i,
  input  wire logic              sample_valid_i,
  input  wire logic [DATA_W-1:0] threshold_initial_value_i,
  input  wire logic [DATA_W-1:0] expected_peak_modulation_i,
  output logic                   slice_bit_o,
  output logic                   slice_valid_o,
  output logic [DATA_W-1:0]      threshold_o,
  output logic                   init_update_o,
  output logic [DATA_W-1:0]      init_value_o,
  output logic [1:0]             gap_count_o,
  output logic [1:0]             slicer_type_o,
  output logic                   config_switch_o
);
  localparam int FW = rpsc_pkg::FRAC_W;
  localparam int AW = DATA_W + FW;

  if (DATA_W < 4 || DATA_W > 16)
  begin : g_width_check
    $error("DATA_W must lie between 4 and 16");
  end

  typedef struct packed {
    logic [7:0]        wake;
    logic [7:0]        pre;
    logic [7:0]        data;
    logic [7:0]        rdata;
    logic [AW-1:0]     thr_acc;
    logic              slice_lvl;
    logic              slice_vld;
    logic              init_upd;
    logic [DATA_W-1:0] init_val;
    logic [1:0]        gap;
    logic [1:0]        stype;
    logic [1:0]        phase_q;
    logic              sw;
  } rpsc_state_t;

  localparam rpsc_state_t S_RST = '{
    wake:    rpsc_pkg::WAKE_SET_RST,
    pre:     rpsc_pkg::PRE_SET_RST,
    data:    rpsc_pkg::DATA_SET_RST,
    rdata:   rpsc_pkg::RDATA_RST,
    default: '0
  };

  rpsc_state_t s_r;
  rpsc_state_t s_nxt;

  // Active configuration, chosen by phase
  logic [1:0]        act_gap;
  logic [1:0]        act_type;
  logic [1:0]        act_init;
  logic [1:0]        act_acq;
  logic              acq_start;
  logic              acq_stop;
  logic              acq_done;
  logic [DATA_W-1:0] acq_result;
  logic              edge_clear;
  logic              edge_decision;
  logic [DATA_W-1:0] thr_now;
  logic              phase_change;
  logic signed [AW:0] lp_diff;
  logic signed [AW:0] lp_step;

  assign thr_now      = s_r.thr_acc[AW-1:FW];
  assign phase_change = (phase_i != s_r.phase_q);

  always_comb
  begin
    act_gap  = 2'b00;
    act_type = 2'b00;
    act_init = 2'b00;
    act_acq  = 2'b00;
    case (rpsc_pkg::rpsc_phase_t'(phase_i))
      rpsc_pkg::PH_WAKE:
      begin
        act_gap  = s_r.wake[rpsc_pkg::GAP_MSB:rpsc_pkg::GAP_LSB];
        act_type = s_r.wake[rpsc_pkg::TYPE_MSB:rpsc_pkg::TYPE_LSB];
        act_init = s_r.wake[rpsc_pkg::INIT_MSB:rpsc_pkg::INIT_LSB];
        act_acq  = s_r.wake[rpsc_pkg::ACQ_MSB:rpsc_pkg::ACQ_LSB];
      end
      rpsc_pkg::PH_PRE:
      begin
        act_gap  = s_r.pre[rpsc_pkg::GAP_MSB:rpsc_pkg::GAP_LSB];
        act_type = s_r.pre[rpsc_pkg::TYPE_MSB:rpsc_pkg::TYPE_LSB];
        act_init = s_r.pre[rpsc_pkg::INIT_MSB:rpsc_pkg::INIT_LSB];
        act_acq  = s_r.pre[rpsc_pkg::ACQ_MSB:rpsc_pkg::ACQ_LSB];
      end
      rpsc_pkg::PH_DATA:
      begin
        act_gap  = s_r.data[rpsc_pkg::GAP_MSB:rpsc_pkg::GAP_LSB];
        act_type = s_r.data[rpsc_pkg::TYPE_MSB:rpsc_pkg::TYPE_LSB];
        act_init = s_r.pre[rpsc_pkg::INIT_MSB:rpsc_pkg::INIT_LSB];
        act_acq  = s_r.pre[rpsc_pkg::ACQ_MSB:rpsc_pkg::ACQ_LSB];
      end
      default:
      begin
        act_gap  = 2'b00;
        act_type = 2'b00;
        act_init = 2'b00;
        act_acq  = 2'b00;
      end
    endcase
  end

  // Acquisition control; an idle receiver stops any window in flight
  always_comb
  begin
    acq_start = (rx_start_i && act_init[1])
             || (chip_timeout_i && act_init == rpsc_pkg::INIT_ACQ_RST);
    acq_stop  = !act_init[1] || phase_i == rpsc_pkg::PH_IDLE;
  end

  // Edge tracking is stale after a phase change or a type switch
  assign edge_clear = rx_start_i || phase_change || act_type != rpsc_pkg::SL_EDGE;

  rpsc_acq #(
    .DATA_W(DATA_W)
  ) u_acq (
    .mclk_i         (mclk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .start_i        (acq_start),
    .stop_i         (acq_stop),
    .len_i          (act_acq),
    .sample_i       (sample_i),
    .sample_valid_i (sample_valid_i),
    .result_o       (acq_result),
    .result_valid_o (acq_done)
  );

  rpsc_edge #(
    .DATA_W(DATA_W)
  ) u_edge (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .clear_i    (edge_clear),
    .sample_i   (sample_i),
    .valid_i    (sample_valid_i),
    .peak_i     (expected_peak_modulation_i),
    .decision_o (edge_decision)
  );

  always_comb
  begin
    lp_diff = $signed({1'b0, sample_i, {FW{1'b0}}}) - $signed({1'b0, s_r.thr_acc});
    if (act_type == rpsc_pkg::SL_LP_SHORT)
      lp_step = lp_diff >>> rpsc_pkg::LPF_SHORT_SHIFT;
    else
      lp_step = lp_diff >>> rpsc_pkg::LPF_LONG_SHIFT;

    s_nxt = s_r;
    s_nxt.init_upd = 1'b0;
    s_nxt.slice_vld = 1'b0;
    s_nxt.phase_q = phase_i;
    s_nxt.sw = phase_change;
    s_nxt.gap = act_gap;
    s_nxt.stype = act_type;

    // Register port; a read and a write in one cycle return the old value
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        rpsc_pkg::WAKE_SET_ADDR: s_nxt.wake = reg_wdata_i;
        rpsc_pkg::PRE_SET_ADDR:  s_nxt.pre  = reg_wdata_i;
        rpsc_pkg::DATA_SET_ADDR: s_nxt.data = reg_wdata_i;
        default:                 s_nxt.wake = s_r.wake;
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        rpsc_pkg::WAKE_SET_ADDR: s_nxt.rdata = s_r.wake;
        rpsc_pkg::PRE_SET_ADDR:  s_nxt.rdata = s_r.pre;
        rpsc_pkg::DATA_SET_ADDR: s_nxt.rdata = s_r.data;
        default:                 s_nxt.rdata = 8'h00;
      endcase
    end

    // Threshold: a load beats the filter; code 00 never loads
    if (rx_start_i && act_init == rpsc_pkg::INIT_REG)
      s_nxt.thr_acc = {threshold_initial_value_i, {FW{1'b0}}};
    else if (acq_done && act_init[1])
    begin
      s_nxt.thr_acc  = {acq_result, {FW{1'b0}}};
      s_nxt.init_val = acq_result;
      s_nxt.init_upd = 1'b1;
    end
    else if (sample_valid_i && act_type[1])
      s_nxt.thr_acc = AW'($signed({1'b0, s_r.thr_acc}) + lp_step);

    // Slicing; type 01 leaves the threshold as it stands
    if (sample_valid_i)
    begin
      s_nxt.slice_vld = 1'b1;
      if (act_type == rpsc_pkg::SL_EDGE)
        s_nxt.slice_lvl = edge_decision;
      else
        s_nxt.slice_lvl = (sample_i > thr_now);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      s_r <= S_RST;
    else if (ce_i)
      s_r <= s_nxt;
  end

  assign reg_rdata_o     = s_r.rdata;
  assign slice_bit_o     = s_r.slice_lvl;
  assign slice_valid_o   = s_r.slice_vld;
  assign threshold_o     = thr_now;
  assign init_update_o   = s_r.init_upd;
  assign init_value_o    = s_r.init_val;
  assign gap_count_o     = s_r.gap;
  assign slicer_type_o   = s_r.stype;
  assign config_switch_o = s_r.sw;

  a_wake_type_sel: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && phase_i == rpsc_pkg::PH_WAKE)
    |=> slicer_type_o == $past(s_r.wake[5:4]) && gap_count_o == $past(s_r.wake[7:6]))
    else $error("wakeup phase not using wakeup settings");

  a_pre_type_sel: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && phase_i == rpsc_pkg::PH_PRE) |=> slicer_type_o == $past(s_r.pre[5:4]))
    else $error("preamble phase slicer type wrong");

  a_pre_gap_sel: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && phase_i == rpsc_pkg::PH_PRE) |=> gap_count_o == $past(s_r.pre[7:6]))
    else $error("preamble phase gap count wrong");

  a_data_cfg_sel: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && phase_i == rpsc_pkg::PH_DATA)
    |=> gap_count_o == $past(s_r.data[7:6]) && slicer_type_o == $past(s_r.data[5:4]))
    else $error("data phase settings wrong");

  a_init_reg_load: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && rx_start_i && act_init == 2'b01) |=> threshold_o == $past(threshold_initial_value_i))
    else $error("threshold not loaded from initial value");

  a_hold_thresh: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && act_type == 2'b01 && !acq_done && !(rx_start_i && act_init == 2'b01))
    |=> $stable(threshold_o))
    else $error("held threshold changed");

  a_never_init: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && act_init == 2'b00 && !act_type[1]) |=> $stable(threshold_o) && !init_update_o)
    else $error("threshold loaded with init code 00");

  a_acq_update: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && acq_done && act_init[1] && !(rx_start_i && act_init == 2'b01))
    |=> init_update_o && threshold_o == init_value_o && init_value_o == $past(acq_result))
    else $error("acquisition result not written");

  a_timeout_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && chip_timeout_i && act_init == 2'b11 && act_acq != 2'b00)
    |=> u_acq.s_r.run && u_acq.s_r.cnt == '0)
    else $error("chip timeout did not restart acquisition");

  a_lp_short_toward: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && sample_valid_i && act_type == 2'b10 && !acq_done && !rx_start_i
     && sample_i >= thr_now) |=> threshold_o >= $past(thr_now))
    else $error("short filter moved away from sample");

  a_phase_switch: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && phase_i != s_r.phase_q) |=> config_switch_o)
    else $error("phase change not flagged");

  // Enable low must leave threshold, type, gap, valid, read data and update flag where they were
  a_ce_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
    !ce_i |=> $stable(threshold_o) && $stable(slicer_type_o) && $stable(gap_count_o)
      && $stable(slice_valid_o) && $stable(reg_rdata_o) && $stable(init_update_o))
    else $error("state moved while clock enable low");

  a_data_acq_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && phase_i == rpsc_pkg::PH_DATA && acq_done && s_r.pre[3]) |=> init_update_o)
    else $error("data phase ignored preamble init mode");

  a_idle_cfg_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && phase_i == rpsc_pkg::PH_IDLE)
    |=> gap_count_o == 2'b00 && slicer_type_o == 2'b00 && !init_update_o)
    else $error("idle phase configuration not cleared");

  a_slice_valid: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i |=> slice_valid_o == $past(sample_valid_i))
    else $error("slice valid does not follow sample");

  a_level_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && sample_valid_i && act_type != 2'b00)
    |=> slice_bit_o == ($past(sample_i) > $past(thr_now)))
    else $error("level slice decision wrong");

  a_lp_long_toward: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && sample_valid_i && act_type == 2'b11 && !acq_done && !rx_start_i
     && sample_i >= thr_now) |=> threshold_o >= $past(thr_now))
    else $error("long filter moved away from sample");

  a_init_reg_no_acq: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && act_init == 2'b01) |=> !init_update_o)
    else $error("acquisition update with init code 01");

  // Writes land one cycle after the strobe
  a_reg_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == rpsc_pkg::PRE_SET_ADDR) |=> s_r.pre == $past(reg_wdata_i))
    else $error("settings write did not land");

  a_unmapped_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && reg_rd_i
     && (reg_addr_i < rpsc_pkg::WAKE_SET_ADDR || reg_addr_i > rpsc_pkg::DATA_SET_ADDR))
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ===== verif/rpsc_rx_front.sv
`timescale 1ns/1ps
module rpsc_rx_front (
  input  wire logic  mclk_i,
  output logic [1:0] phase_o,
  output logic       rx_start_o,
  output logic       chip_timeout_o,
  output logic [7:0] sample_o,
  output logic       sample_valid_o
);
  initial
  begin
    phase_o        = 2'h0;
    rx_start_o     = 1'b0;
    chip_timeout_o = 1'b0;
    sample_o       = 8'h00;
    sample_valid_o = 1'b0;
  end

  task automatic go_phase(input logic [1:0] p);
    @(negedge mclk_i);
    phase_o = p;
  endtask

  // Event strobes last one cycle, as the sequencer issues them
  task automatic strobe(input bit tmo);
    @(negedge mclk_i);
    if (tmo)
      chip_timeout_o = 1'b1;
    else
      rx_start_o = 1'b1;
    @(negedge mclk_i);
    rx_start_o     = 1'b0;
    chip_timeout_o = 1'b0;
  endtask

  // Data is not held after a chip, so stale data cannot pass for fresh
  task automatic chip(input logic [7:0] v);
    @(negedge mclk_i);
    sample_o       = v;
    sample_valid_o = 1'b1;
    @(negedge mclk_i);
    sample_o       = ~v;
    sample_valid_o = 1'b0;
  endtask
endmodule

// ===== verif/rpsc_slicer_cfg_tb_top.sv
`timescale 1ns/1ps
module rpsc_slicer_cfg_tb_top;
  logic       mclk_i;
  logic       rst_i;
  logic       ce;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] thr_init;
  logic [7:0] peak;
  logic [7:0] rdata, sample, thr_o, init_val;
  logic [1:0] phase, gap_o, type_o;
  logic       rx_start, tmo, s_valid, bit_o, bit_valid, init_upd, sw_o;
  logic [7:0] rg[3];
  int         fails     = 0;
  int         cmp_count = 0;
  int         thr;
  int         acc;

  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  rpsc_rx_front rpsc_rx_front_i (.mclk_i(mclk_i), .phase_o(phase), .rx_start_o(rx_start),
    .chip_timeout_o(tmo), .sample_o(sample), .sample_valid_o(s_valid));

  rpsc_slicer_cfg rpsc_slicer_cfg_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .phase_i(phase), .rx_start_i(rx_start),
    .chip_timeout_i(tmo), .sample_i(sample), .sample_valid_i(s_valid),
    .threshold_initial_value_i(thr_init), .expected_peak_modulation_i(peak),
    .slice_bit_o(bit_o), .slice_valid_o(bit_valid), .threshold_o(thr_o),
    .init_update_o(init_upd), .init_value_o(init_val), .gap_count_o(gap_o),
    .slicer_type_o(type_o), .config_switch_o(sw_o));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
    if (a >= 8'h2b && a <= 8'h2d)
      rg[a - 8'h2b] = d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    d        = rdata;
  endtask

  function automatic logic [7:0] cfg(input int p);
    return (p == 0) ? 8'h00 : rg[p - 1];
  endfunction

  // Level slicer model: decide against the threshold before this sample's update
  task automatic slice_chk(input logic [7:0] s, input int sh);
    logic b;
    int   si;
    si = s;
    b  = (si > thr);
    if (sh > 0)
    begin
      acc = acc + ((si * 16 - acc) >>> sh);
      thr = acc >>> 4;
    end
    rpsc_rx_front_i.chip(s);
    chk(bit_valid, 8'h01, "slice valid");
    chk(bit_o, b, "slice bit");
    chk(thr_o, thr[7:0], "threshold");
  endtask

  task automatic acq(input int len, input bit cut);
    int         sum;
    int         i;
    logic [7:0] s;
    sum = 0;
    rpsc_rx_front_i.strobe(1'b0);
    if (cut)
    begin
      repeat (2) rpsc_rx_front_i.chip(8'hff);
      rpsc_rx_front_i.strobe(1'b1);
    end
    for (i = 0; i < (2 << len); i++)
    begin
      s   = 8'($urandom);
      sum = sum + s;
      rpsc_rx_front_i.chip(s);
    end
    for (i = 0; i < 8 && init_upd !== 1'b1; i++)
      @(negedge mclk_i);
    thr = sum >> (len + 1);
    acc = thr * 16;
    chk(init_upd, 8'h01, "init update");
    chk(init_val, thr[7:0], "init value");
    chk(thr_o, thr[7:0], "acquired threshold");
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] base;
    int         p;
    int         prev;
    int         k;
    rst_i       = 1'b1;
    ce          = 1'b1;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    thr_init    = 8'h00;
    peak        = 8'h00;
    void'($urandom(32'heaa7c65a));
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    for (k = 0; k < 4; k++)
    begin
      rd(8'(8'h2b + k), d);
      chk(d, 8'h00, "reset value");
      wr(8'(8'h2b + k), 8'($urandom));
      rd(8'(8'h2b + k), d);
      chk(d, (k == 3) ? 8'h00 : rg[k], "read back");
    end
    $display("test registers done");
    prev = 0;
    repeat (6)
    begin
      for (k = 0; k < 3; k++)
        wr(8'(8'h2b + k), 8'($urandom));
      for (p = 0; p < 4; p++)
      begin
        rpsc_rx_front_i.go_phase(p[1:0]);
        @(negedge mclk_i);
        chk(gap_o, cfg(p) >> 6, "gap count");
        chk(type_o, (cfg(p) >> 4) & 8'h03, "slicer type");
        chk(sw_o, (p != prev), "phase switch");
        prev = p;
      end
    end
    $display("test phase config done");
    rpsc_rx_front_i.go_phase(2'h1);
    wr(8'h2b, 8'h14);
    thr_init = 8'($urandom);
    rpsc_rx_front_i.strobe(1'b0);
    thr = thr_init;
    chk(thr_o, thr_init, "threshold load");
    repeat (6) slice_chk(8'($urandom), 0);
    wr(8'h2b, 8'h10);
    thr_init = ~thr_init;
    rpsc_rx_front_i.strobe(1'b0);
    chk(thr_o, thr[7:0], "no load");
    acc = thr * 16;
    for (k = 2; k < 4; k++)
    begin
      wr(8'h2b, 8'(k << 4));
      repeat (16) slice_chk(8'($urandom), 2 * k - 2);
    end
    $display("test level slicer done");
    // Enable low: a chip and a phase change must both be lost
    ce = 1'b0;
    rpsc_rx_front_i.chip(8'($urandom));
    rpsc_rx_front_i.go_phase(2'h2);
    @(negedge mclk_i);
    chk(thr_o, thr[7:0], "frozen threshold");
    chk(bit_valid, 8'h01, "frozen valid");
    chk({type_o, gap_o, sw_o}, 8'h18, "frozen config");
    ce = 1'b1;
    $display("test clock enable done");
    for (k = 1; k < 4; k++)
    begin
      rpsc_rx_front_i.go_phase(2'h0);
      wr(8'h2b, 8'(8'h18 | k));
      rpsc_rx_front_i.go_phase(2'h1);
      acq(k, 1'b0);
    end
    rpsc_rx_front_i.go_phase(2'h0);
    wr(8'h2b, 8'h00);
    wr(8'h2c, 8'h19);
    wr(8'h2d, 8'h10);
    rpsc_rx_front_i.go_phase(2'h3);
    acq(1, 1'b0);
    rpsc_rx_front_i.go_phase(2'h0);
    wr(8'h2b, 8'h1e);
    rpsc_rx_front_i.go_phase(2'h1);
    acq(2, 1'b1);
    wr(8'h2b, 8'h18);
    rpsc_rx_front_i.strobe(1'b0);
    repeat (20) rpsc_rx_front_i.chip(8'($urandom));
    chk(thr_o, thr[7:0], "zero length");
    $display("test acquisition done");
    rpsc_rx_front_i.go_phase(2'h0);
    wr(8'h2b, 8'h00);
    rpsc_rx_front_i.go_phase(2'h1);
    base = 8'($urandom_range(100));
    peak = 8'(20 + $urandom_range(40));
    rpsc_rx_front_i.strobe(1'b0);
    rpsc_rx_front_i.chip(base);
    chk(bit_o, 8'h00, "edge start");
    rpsc_rx_front_i.chip(base + peak);
    chk(bit_o, 8'h01, "edge rise");
    rpsc_rx_front_i.chip(base);
    chk(bit_o, 8'h00, "edge fall");
    $display("test edge slicer done");
    tally_and_finish();
  end

  // Whole run is a few hundred cycles; this bound is generous
  initial
  begin
    #(50 * 40000);
    fails++;
    tally_and_finish();
  end
endmodule
